// File: pdcb_pkg.sv
// Package for the PLL divider configuration bank: offsets, fields, resets.
// Assumes a byte-wide register port with 8-bit addresses.
package pdcb_pkg;
   localparam logic [7:0] PDCB_OFS_MULT_HI = 8'h36;
   localparam logic [7:0] PDCB_OFS_FRAC_LO = 8'h37;
   localparam logic [7:0] PDCB_OFS_INT_LO  = 8'h38;
   localparam logic [7:0] PDCB_OFS_NPDM    = 8'h39;

   localparam logic [7:0] PDCB_RST_MULT_HI = 8'h00;
   localparam logic [7:0] PDCB_RST_FRAC_LO = 8'h00;
   localparam logic [7:0] PDCB_RST_INT_LO  = 8'h08;
   localparam logic [7:0] PDCB_RST_NPDM    = 8'h20;

   localparam int PDCB_POS_INT_HI  = 7;
   localparam int PDCB_POS_HALF    = 6;
   localparam int PDCB_POS_N_DIVIDER_CODE    = 5;
   localparam int PDCB_POS_PDM     = 2;
   localparam logic [7:0] PDCB_NPDM_RSVD_MASK = 8'h03;

   localparam logic [13:0] PDCB_FRAC_MAX   = 14'h270F;
   localparam logic [2:0]  PDCB_PDM_MAX    = 3'h4;
   localparam logic [3:0]  PDCB_N_DIVIDER_CODE_ZERO  = 4'h8;

   // Decoded settings for the clock tree
   typedef struct packed {
      logic [8:0]  int_mult;
      logic [13:0] frac_mult;
      logic        half_div;
      logic [3:0]  n_ratio;
      logic [4:0]  pdm_ratio;
   } pdcb_clk_cfg_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pdcb_reg_req_t;
endpackage

// File: pdcb_decode.sv
// Decoder turning raw divider fields into ratios and multipliers.
// Assumes its inputs are register outputs on the same clock.
`timescale 1ns/1ps
module pdcb_decode
   import pdcb_pkg::*;
(
   input  wire logic [7:0]    i_mult_hi,
   input  wire logic [7:0]    i_frac_lo,
   input  wire logic [7:0]    i_int_lo,
   input  wire logic [7:0]    i_npdm,
   output pdcb_clk_cfg_t      o_cfg,
   output logic               o_code_bad
);
   logic [2:0] n_divider_code;
   logic [2:0] pdm;

   always_comb begin
      n_divider_code = i_npdm[PDCB_POS_N_DIVIDER_CODE +: 3];
      pdm  = i_npdm[PDCB_POS_PDM +: 3];
      o_cfg.int_mult  = {i_mult_hi[PDCB_POS_INT_HI], i_int_lo}; // see (RL1)
      o_cfg.frac_mult = {i_mult_hi[5:0], i_frac_lo};            // see (RL3)
      o_cfg.half_div  = i_mult_hi[PDCB_POS_HALF];               // see (RL5)
      o_cfg.n_ratio   = (n_divider_code == 3'h0) ? PDCB_N_DIVIDER_CODE_ZERO
                                      : {1'b0, n_divider_code};          // see (RL6)
      o_cfg.pdm_ratio = 5'h01 << pdm;                           // see (RL7)
      // Reserved codes are flagged rather than silently remapped
      o_code_bad = (o_cfg.int_mult == 9'h000)                   // see (RL2)
                || (o_cfg.frac_mult > PDCB_FRAC_MAX)            // see (RL4)
                || (pdm > PDCB_PDM_MAX);                        // see (RL7)
   end
endmodule

// File: pdcb_top.sv
// Contract
// (RL1) Integer multiplier is high bit above low byte
// (RL2) Integer code zero reserved; others equal code
// (RL3) Fraction is six high bits above low byte
// (RL4) Fraction codes 0..9999 valid; above reserved
// (RL5) Half-divide bit halves PLL divided clock
// (RL6) N code 1..7 is ratio; zero means eight
// (RL7) PDM codes 0..4 divide by powers of two
// (RL8) Auto detection overrides programmed multipliers and dividers; the code keeps half-divide programmed
// (RL9) Low two N/PDM bits reserved, read zero
// (RL10) Effective factor is J plus D over 10000
//
// Top of the PLL divider configuration bank: four byte registers on the
// control port, decoded into clock tree settings.
// Assumes the control port and auto-detect logic share i_sys_clk.
`timescale 1ns/1ps
module pdcb_top
   import pdcb_pkg::*;
(
   input  wire logic           i_sys_clk,
   input  wire logic           i_rst_b,
   input  wire pdcb_reg_req_t  i_req,
   input  wire logic           i_auto_det_en,
   input  wire pdcb_clk_cfg_t  i_auto_cfg,
   output logic [7:0]          o_rdata,
   output pdcb_clk_cfg_t       o_cfg,
   output logic                o_code_bad
);
   logic [7:0]    mult_hi_r, mult_hi_nxt;
   logic [7:0]    frac_lo_r, frac_lo_nxt;
   logic [7:0]    int_lo_r,  int_lo_nxt;
   logic [7:0]    npdm_r,    npdm_nxt;
   logic [7:0]    rdata_r,   rdata_nxt;
   pdcb_clk_cfg_t cfg_r,     cfg_nxt;
   logic          bad_r,     bad_nxt;
   pdcb_clk_cfg_t dec_cfg;
   logic          dec_bad;

   pdcb_decode u_dec (
      .i_mult_hi  (mult_hi_r),
      .i_frac_lo  (frac_lo_r),
      .i_int_lo   (int_lo_r),
      .i_npdm     (npdm_r),
      .o_cfg      (dec_cfg),
      .o_code_bad (dec_bad)
   );

   always_comb begin
      mult_hi_nxt = mult_hi_r;
      frac_lo_nxt = frac_lo_r;
      int_lo_nxt  = int_lo_r;
      npdm_nxt    = npdm_r;
      if (i_req.wr) begin
         unique case (i_req.addr)
            PDCB_OFS_MULT_HI: mult_hi_nxt = i_req.wdata;
            PDCB_OFS_FRAC_LO: frac_lo_nxt = i_req.wdata;
            PDCB_OFS_INT_LO:  int_lo_nxt  = i_req.wdata;
            // Reserved bits are never stored, so they cannot read back
            PDCB_OFS_NPDM:    npdm_nxt = i_req.wdata
                                         & ~PDCB_NPDM_RSVD_MASK; // see (RL9)
            default: ;
         endcase
      end
      unique case (i_req.addr)
         PDCB_OFS_MULT_HI: rdata_nxt = mult_hi_r;
         PDCB_OFS_FRAC_LO: rdata_nxt = frac_lo_r;
         PDCB_OFS_INT_LO:  rdata_nxt = int_lo_r;
         PDCB_OFS_NPDM:    rdata_nxt = npdm_r;
         default:          rdata_nxt = 8'h00;
      endcase
      // Half-divide is not covered by auto detection and stays programmed
      cfg_nxt = dec_cfg;
      bad_nxt = dec_bad;
      if (i_auto_det_en) begin
         cfg_nxt.int_mult  = i_auto_cfg.int_mult;   // see (RL8)
         cfg_nxt.frac_mult = i_auto_cfg.frac_mult;  // see (RL8)
         cfg_nxt.n_ratio   = i_auto_cfg.n_ratio;    // see (RL8)
         cfg_nxt.pdm_ratio = i_auto_cfg.pdm_ratio;  // see (RL8)
         bad_nxt = 1'b0;
      end
   end

   // Factor J + D/10000 (see (RL10)) is consumed downstream from o_cfg
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         mult_hi_r <= PDCB_RST_MULT_HI;
         frac_lo_r <= PDCB_RST_FRAC_LO;
         int_lo_r  <= PDCB_RST_INT_LO;
         npdm_r    <= PDCB_RST_NPDM;
         rdata_r   <= 8'h00;
         cfg_r     <= '0;
         bad_r     <= 1'b0;
      end else begin
         mult_hi_r <= mult_hi_nxt;
         frac_lo_r <= frac_lo_nxt;
         int_lo_r  <= int_lo_nxt;
         npdm_r    <= npdm_nxt;
         rdata_r   <= rdata_nxt;
         cfg_r     <= cfg_nxt;
         bad_r     <= bad_nxt;
      end
   end

   assign o_rdata    = rdata_r;
   assign o_cfg      = cfg_r;
   assign o_code_bad = bad_r;

   a_npdm_rsvd_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (npdm_r & PDCB_NPDM_RSVD_MASK) == 8'h00) // see (RL9)
      else $error("reserved divider bits set");

   a_int_mult_join: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !i_auto_det_en |=> o_cfg.int_mult ==
         {$past(mult_hi_r[7]), $past(int_lo_r)}) // see (RL1)
      else $error("integer multiplier mismatch");

   a_frac_mult_join: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !i_auto_det_en |=> o_cfg.frac_mult ==
         {$past(mult_hi_r[5:0]), $past(frac_lo_r)}) // see (RL3)
      else $error("fractional multiplier mismatch");

   a_half_div_pass: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      ##1 o_cfg.half_div == $past(mult_hi_r[6])) // see (RL5)
      else $error("half divide mismatch");

   a_n_divider_code_zero_8: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!i_auto_det_en && npdm_r[7:5] == 3'h0) |=> o_cfg.n_ratio == 4'h8)
      else $error("n ratio for code zero wrong"); // see (RL6)

   a_n_divider_code_code_pass: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!i_auto_det_en && npdm_r[7:5] != 3'h0) |=>
         o_cfg.n_ratio == {1'b0, $past(npdm_r[7:5])}) // see (RL6)
      else $error("n ratio mismatch");

   a_pdm_pow2: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!i_auto_det_en && npdm_r[4:2] <= 3'h4) |=>
         o_cfg.pdm_ratio == (5'h01 << $past(npdm_r[4:2]))) // see (RL7)
      else $error("pdm ratio mismatch");

   a_int_zero_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!i_auto_det_en && mult_hi_r[7] == 1'b0 && int_lo_r == 8'h00)
         |=> o_code_bad) // see (RL2)
      else $error("zero multiplier not flagged");

   a_frac_rsvd_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!i_auto_det_en && {mult_hi_r[5:0], frac_lo_r} > 14'h270F)
         |=> o_code_bad) // see (RL4)
      else $error("reserved fraction not flagged");

   a_auto_override: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      i_auto_det_en |=> (o_cfg.int_mult == $past(i_auto_cfg.int_mult)
         && o_cfg.n_ratio == $past(i_auto_cfg.n_ratio)
         && !o_code_bad)) // see (RL8)
      else $error("auto detection not applied");
endmodule

// File: tb_pdcb_top.sv
// Testbench for the PLL divider configuration bank register slice.
// Assumes pdcb_pkg and the design files are compiled before it.
`timescale 1ns/1ps
module tb_top
   import pdcb_pkg::*;
;
   logic          sys_clk  = 1'b0;
   logic          rst_b    = 1'b0;
   pdcb_reg_req_t req      = '0;
   logic          auto_en  = 1'b0;
   pdcb_clk_cfg_t auto_cfg = '0;
   logic [7:0]    rdata;
   pdcb_clk_cfg_t cfg;
   logic          bad;
   int            fails    = 0;
   int            checked  = 0;
   int            cycles   = 0;
   logic [2:0]    n;
   logic [2:0]    p;

   pdcb_top u_dut (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_req(req),
      .i_auto_det_en(auto_en), .i_auto_cfg(auto_cfg), .o_rdata(rdata),
      .o_cfg(cfg), .o_code_bad(bad));

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic results();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{wr: 1'b1, addr: a, wdata: d};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask

   // Address is held so the registered read data cannot move under us
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
      repeat (2) @(posedge sys_clk);
      #1 chk({25'h0, rdata}, {25'h0, exp});
   endtask

   task automatic cfg_is(input pdcb_clk_cfg_t exp, input logic exp_bad);
      repeat (3) @(posedge sys_clk);
      #1 chk(cfg, exp);
      chk({32'h0, bad}, {32'h0, exp_bad});
   endtask

   function automatic pdcb_clk_cfg_t mk(input logic [8:0] j,
      input logic [13:0] d, input logic h, input logic [3:0] nr,
      input logic [4:0] pr);
      mk = '{j, d, h, nr, pr};
   endfunction

   initial begin
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      cfg_is(mk(9'h008, 14'h0000, 1'b0, 4'h1, 5'h01), 1'b0);
      rd(8'h36, 8'h00);
      rd(8'h37, 8'h00);
      rd(8'h38, 8'h08);
      rd(8'h39, 8'h20);
      rd(8'h3A, 8'h00);
      wr(8'h36, 8'hE7);
      wr(8'h37, 8'h0F);
      wr(8'h38, 8'hFF);
      cfg_is(mk(9'h1FF, 14'h270F, 1'b1, 4'h1, 5'h01), 1'b0);
      rd(8'h36, 8'hE7);
      wr(8'h37, 8'h10);
      cfg_is(mk(9'h1FF, 14'h2710, 1'b1, 4'h1, 5'h01), 1'b1);
      wr(8'h36, 8'h00);
      wr(8'h37, 8'h00);
      wr(8'h38, 8'h00);
      cfg_is(mk(9'h000, 14'h0000, 1'b0, 4'h1, 5'h01), 1'b1);
      wr(8'h38, 8'h01);
      for (int i = 0; i < 64; i++) begin
         n = i[5:3];
         p = i[2:0];
         wr(8'h39, {n, p, 2'b11});
         cfg_is(mk(9'h001, 14'h0000, 1'b0, (n == 3'h0) ? 4'h8 : {1'b0, n},
            (p < 3'h5) ? 5'h01 << p : 5'h00), p > 3'h4);
         rd(8'h39, {n, p, 2'b00});
      end
      @(posedge sys_clk);
      auto_cfg <= mk(9'h123, 14'h1234, 1'b0, 4'h5, 5'h10);
      auto_en <= 1'b1;
      cfg_is(mk(9'h123, 14'h1234, 1'b0, 4'h5, 5'h10), 1'b0);
      wr(8'h36, 8'h40);
      cfg_is(mk(9'h123, 14'h1234, 1'b1, 4'h5, 5'h10), 1'b0);
      @(posedge sys_clk);
      auto_en <= 1'b0;
      cfg_is(mk(9'h001, 14'h0000, 1'b1, 4'h7, 5'h00), 1'b1);
      results();
   end

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         results();
      end
   end
endmodule
